// ### rtl/asb_consts.vh
// Constants for the serial channel: register offsets, field positions, reset values and divider figures.
// Assumes an APB master with 32-bit data; registers sit on aligned words in the low bits.
// Overview of operation
// R1 - Speed select codes 0 to 6 divide by 1, 2, 4, 8, 16, 32 or 64, and code 7 takes the external clock.
// R2 - The external clock fed in must not run faster than the system clock divided by forty.
// R3 - The divide-ratio bit sets one stage to divide by 64 when 1 and by 16 when 0.
// R4 - With the external clock, only the divide-ratio bit changes the division applied to it.
// R5 - The parity sense bit picks even parity at 0 and odd at 1, and matters only while parity is on.
// R6 - Reading the shared prescaler bit returns the present clear-to-send pin level.
// R7 - While the clear-to-send pin is high, the receive-full flag is not set and characters are ignored.
// R8 - Writing the shared prescaler bit picks a prescaler of 10 for 0 and of 30 for 1.
// R9 - The bit rate comes from prescaler, divide-ratio stage and speed-select divider in cascade.
// R10 - With all rate fields zero the channel runs at one 160th of the system clock.
// R11 - In multidrop mode a frame is start bit, data bits, one address-mark bit, then stop bits.
// R12 - The sent address-mark bit equals the address-mark transmit control bit.
// R13 - A byte sent with its address mark at 1 is accepted by stations filtering for marked bytes.
// R14 - With the address filter and multidrop mode on, unmarked bytes are dropped without any flag change.
// R15 - Parity is generated and checked only while parity enable is set.
// R16 - Control B holds speed select in bits 2 to 0, divide ratio in bit 3 and prescaler in bit 5.
// R17 - The divide-ratio stage is the oversampling factor, so a total of 160 gives the listed rates.
`ifndef ASB_CONSTS_VH
`define ASB_CONSTS_VH
`define ASB_OFS_CTL_A 8'h00
`define ASB_OFS_CTL_B 8'h04
`define ASB_OFS_TXD 8'h08
`define ASB_OFS_RXD 8'h0C
`define ASB_OFS_LSR 8'h10
`define ASB_OFS_IST 8'h14
`define ASB_OFS_IMASK 8'h18
`define ASB_CA_STOP2 0
`define ASB_CA_PAR_EN 1
`define ASB_CA_DATA8 2
`define ASB_CA_FILT_EN 3
`define ASB_CA_RX_EN 4
`define ASB_CA_TX_EN 5
`define ASB_CA_RESET 6'h34
`define ASB_CB_SS_HI 2
`define ASB_CB_SS_LO 0
`define ASB_CB_DR 3
`define ASB_CB_ODD 4
`define ASB_CB_PS 5
`define ASB_CB_MP 6
`define ASB_CB_MARK_TX 7
`define ASB_CB_PS_MASK 8'h20
`define ASB_CB_RESET 8'h00
`define ASB_LS_RXF 0
`define ASB_LS_TXE 1
`define ASB_LS_OVR 2
`define ASB_LS_FE 3
`define ASB_LS_PE 4
`define ASB_LS_MARK 5
`define ASB_LS_CTS 6
`define ASB_IS_RX 0
`define ASB_IS_TX 1
`define ASB_IS_ERR 2
`define ASB_SS_EXT 3'h7
`define ASB_PS_LIM_LO 5'h09
`define ASB_PS_LIM_HI 5'h1D
`define ASB_OSR_LIM_LO 6'h0F
`define ASB_OSR_LIM_HI 6'h3F
`define ASB_BASE_BITS 4'h8
`define ASB_RX_SR_W 4'hA
`endif

// ### rtl/asb_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous levels; the first stage is read only by the second.
module asb_sync #(
	parameter W = 3
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Raw and synchronised levels
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// Both stages reset high, the idle level of the serial pins.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_ff <= {W{1'b1}};
			sync_ff <= {W{1'b1}};
		end
		else
		begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule

// ### rtl/asb_baud.v
// Sample-rate generator: prescaler then speed-select divider, or external clock edges.
// Assumes ext_rise is a one-cycle pulse made from a synchronised external clock.
`include "asb_consts.vh"
module asb_baud (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Rate settings
	input wire [2:0] ss,
	input wire ps,
	input wire ext_rise,
	// One pulse per oversample period
	output wire sample_tick
);
	reg [4:0] ps_cnt_ff;
	reg [5:0] ss_cnt_ff;
	reg tick_ff;
	wire [4:0] ps_lim;
	wire [5:0] ss_lim;
	wire pre_hit;
	wire ss_hit;

	// Terminal count of the speed-select divider for codes 0 to 6.
	function [5:0] asb_ss_limit;
		input [2:0] code;
		begin
			asb_ss_limit = (6'h01 << code) - 6'h01;
		end
	endfunction

	assign ps_lim = ps ? `ASB_PS_LIM_HI : `ASB_PS_LIM_LO; // [R8]
	assign ss_lim = asb_ss_limit(ss); // [R1]
	assign pre_hit = (ps_cnt_ff == ps_lim);
	assign ss_hit = pre_hit && (ss_cnt_ff == ss_lim);

	// Prescaler feeds the speed-select divider; code 7 bypasses both for the external clock.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ps_cnt_ff <= 5'h00;
			ss_cnt_ff <= 6'h00;
			tick_ff <= 1'b0;
		end
		else
		begin
			ps_cnt_ff <= pre_hit ? 5'h00 : ps_cnt_ff + 5'h01; // [R9]
			if (pre_hit)
			begin
				ss_cnt_ff <= (ss_cnt_ff >= ss_lim) ? 6'h00 : ss_cnt_ff + 6'h01; // [R9]
			end
			if (ss == `ASB_SS_EXT)
			begin
				tick_ff <= ext_rise; // [R1] [R4]
			end
			else
			begin
				tick_ff <= ss_hit;
			end
		end
	end

	assign sample_tick = tick_ff;
endmodule

// ### rtl/asb_top.v
// Serial channel with APB registers: rate control, parity, clear-to-send readback and multidrop framing.
// Assumes an APB master on pclk; the serial pins and the external clock are asynchronous.
`include "asb_consts.vh"
module asb_top (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Serial pins
	input wire cts_n_pin,
	input wire ext_clk_pin,
	input wire rxd_pin,
	output wire txd,
	// Interrupt
	output wire irq
);
	localparam TX_IDLE = 1'b0;
	localparam TX_SHIFT = 1'b1;
	localparam RX_IDLE = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_DATA = 2'h2;

	reg [5:0] ctl_a_ff;
	reg [7:0] ctl_b_ff;
	reg [7:0] tx_hold_ff;
	reg tx_empty_ff;
	reg [7:0] rx_data_ff;
	reg rx_full_ff;
	reg ovr_ff;
	reg fe_ff;
	reg pe_ff;
	reg mark_last_ff;
	reg [2:0] ist_ff;
	reg [2:0] imask_ff;
	reg [31:0] prdata_ff;
	reg pslverr_ff;
	reg ext_prev_ff;
	reg tx_state_ff;
	reg [11:0] tx_sr_ff;
	reg [3:0] tx_bits_ff;
	reg [5:0] tx_cnt_ff;
	reg txd_ff;
	reg [1:0] rx_state_ff;
	reg [9:0] rx_sr_ff;
	reg [3:0] rx_bits_ff;
	reg [5:0] rx_cnt_ff;
	reg [31:0] rd_mux;
	reg rd_hit;
	reg [7:0] lsr;
	reg [11:0] nxt_frame;
	reg [9:0] rx_full_sr;
	reg [9:0] rx_aligned;

	wire cts_n_s;
	wire ext_s;
	wire rxd_s;
	wire sample_tick;
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	wire [2:0] ss = ctl_b_ff[`ASB_CB_SS_HI:`ASB_CB_SS_LO];
	wire dr = ctl_b_ff[`ASB_CB_DR];
	wire odd = ctl_b_ff[`ASB_CB_ODD];
	wire mp = ctl_b_ff[`ASB_CB_MP];
	wire mark_tx = ctl_b_ff[`ASB_CB_MARK_TX];
	wire par_en = ctl_a_ff[`ASB_CA_PAR_EN];
	wire data8 = ctl_a_ff[`ASB_CA_DATA8];
	wire stop2 = ctl_a_ff[`ASB_CA_STOP2];
	wire filt_en = ctl_a_ff[`ASB_CA_FILT_EN];
	wire rx_en = ctl_a_ff[`ASB_CA_RX_EN];
	wire tx_en = ctl_a_ff[`ASB_CA_TX_EN];
	wire extra = mp | par_en; // [R11] [R15]
	wire [5:0] osr_lim = dr ? `ASB_OSR_LIM_HI : `ASB_OSR_LIM_LO; // [R3] [R17]
	wire [5:0] osr_half = {1'b0, osr_lim[5:1]};
	wire [3:0] rx_n = `ASB_BASE_BITS + {3'h0, data8} + {3'h0, extra};
	// A frame starts only on a sample tick, so the start bit is as long as every other bit.
	wire tx_load = (tx_state_ff == TX_IDLE) & tx_en & ~tx_empty_ff & sample_tick;
	wire tx_bit_end = sample_tick & (tx_cnt_ff == osr_lim);
	wire rx_bit_end = sample_tick & (rx_cnt_ff == osr_lim);
	wire rx_fin = (rx_state_ff == RX_DATA) & rx_bit_end & (rx_bits_ff == 4'h1) & rx_en;
	wire [7:0] rx_char = data8 ? rx_aligned[7:0] : {1'b0, rx_aligned[6:0]};
	wire rx_extra = data8 ? rx_aligned[8] : rx_aligned[7];
	wire rx_stop = rx_aligned[rx_n - 4'h1];
	wire rx_par_exp = odd ? ~^rx_char : ^rx_char; // [R5]
	wire rx_drop_mark = mp & filt_en & ~rx_extra; // [R14] [R13]
	wire rx_accept = rx_fin & ~rx_drop_mark & ~cts_n_s; // [R7]
	wire rx_fe = rx_accept & ~rx_stop;
	wire rx_pe = rx_accept & par_en & ~mp & (rx_extra != rx_par_exp); // [R15]
	wire rx_ovr = rx_accept & rx_full_ff & ~(rd & (paddr == `ASB_OFS_RXD));
	wire [2:0] ev = {rx_fe | rx_pe | rx_ovr, tx_load, rx_accept};

	// Parity bit of a character in the chosen sense.
	function asb_parity;
		input [7:0] d;
		input d8;
		input sense_odd;
		reg p;
		begin
			p = d8 ? ^d : ^d[6:0];
			asb_parity = sense_odd ? ~p : p;
		end
	endfunction

	// Bit periods the shifter drives: the frame without its last stop bit, which is left to the idle level.
	function [3:0] asb_frame_len;
		input d8;
		input ex;
		input s2;
		begin
			asb_frame_len = `ASB_BASE_BITS + {3'h0, d8} + {3'h0, ex} + {3'h0, s2};
		end
	endfunction

	// Pin synchronisers for clear-to-send, external clock and receive data.
	asb_sync #(
		.W(3)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({cts_n_pin, ext_clk_pin, rxd_pin}),
		.q({cts_n_s, ext_s, rxd_s})
	);

	// Sample-rate generator; the external clock is expected below a fortieth of pclk.
	asb_baud u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.ss(ss),
		.ps(ctl_b_ff[`ASB_CB_PS]),
		.ext_rise(ext_s & ~ext_prev_ff), // [R2]
		.sample_tick(sample_tick)
	);

	// Line status assembly and read data selection.
	always @*
	begin
		lsr = 8'h00;
		lsr[`ASB_LS_RXF] = rx_full_ff;
		lsr[`ASB_LS_TXE] = tx_empty_ff;
		lsr[`ASB_LS_OVR] = ovr_ff;
		lsr[`ASB_LS_FE] = fe_ff;
		lsr[`ASB_LS_PE] = pe_ff;
		lsr[`ASB_LS_MARK] = mark_last_ff;
		lsr[`ASB_LS_CTS] = cts_n_s;
		rd_hit = 1'b1;
		case (paddr)
			`ASB_OFS_CTL_A: rd_mux = {26'h0, ctl_a_ff};
			`ASB_OFS_CTL_B: rd_mux = {24'h0, (ctl_b_ff & ~`ASB_CB_PS_MASK) | (cts_n_s ? `ASB_CB_PS_MASK : 8'h00)}; // [R6]
			`ASB_OFS_TXD: rd_mux = {24'h0, tx_hold_ff};
			`ASB_OFS_RXD: rd_mux = {24'h0, rx_data_ff};
			`ASB_OFS_LSR: rd_mux = {24'h0, lsr};
			`ASB_OFS_IST: rd_mux = {29'h0, ist_ff};
			`ASB_OFS_IMASK: rd_mux = {29'h0, imask_ff};
			default:
			begin
				rd_mux = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read data and error answer are captured in the setup cycle, so every access takes one cycle.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
			ext_prev_ff <= 1'b1; // Matches the synchroniser reset level, so no false edge follows reset.
		end
		else
		begin
			ext_prev_ff <= ext_s;
			if (setup)
			begin
				prdata_ff <= pwrite ? 32'h0 : rd_mux;
				pslverr_ff <= ~rd_hit;
			end
		end
	end

	// Register file, flags and interrupt status; every hardware set wins over a clear in the same cycle.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_a_ff <= `ASB_CA_RESET;
			ctl_b_ff <= `ASB_CB_RESET; // [R10]
			tx_hold_ff <= 8'h00;
			tx_empty_ff <= 1'b1;
			rx_data_ff <= 8'h00;
			rx_full_ff <= 1'b0;
			ovr_ff <= 1'b0;
			fe_ff <= 1'b0;
			pe_ff <= 1'b0;
			mark_last_ff <= 1'b0;
			ist_ff <= 3'h0;
			imask_ff <= 3'h0;
		end
		else
		begin
			if (wr && paddr == `ASB_OFS_CTL_A)
				ctl_a_ff <= pwdata[5:0];
			if (wr && paddr == `ASB_OFS_CTL_B)
				ctl_b_ff <= pwdata[7:0]; // [R16] [R8]
			if (wr && paddr == `ASB_OFS_IMASK)
				imask_ff <= pwdata[2:0];
			// Holding register: a write while full is ignored.
			if (wr && paddr == `ASB_OFS_TXD && tx_empty_ff)
			begin
				tx_hold_ff <= pwdata[7:0];
				tx_empty_ff <= 1'b0;
			end
			else if (tx_load)
			begin
				tx_empty_ff <= 1'b1;
			end
			// Receive data register; an overrun keeps the older character.
			if (rx_accept && !rx_ovr)
			begin
				rx_data_ff <= rx_char;
				mark_last_ff <= mp & rx_extra;
				rx_full_ff <= 1'b1;
			end
			else if (rd && paddr == `ASB_OFS_RXD)
			begin
				rx_full_ff <= 1'b0;
			end
			// Error flags clear by writing ones to the line status register.
			if (rx_ovr)
				ovr_ff <= 1'b1;
			else if (wr && paddr == `ASB_OFS_LSR && pwdata[`ASB_LS_OVR])
				ovr_ff <= 1'b0;
			if (rx_fe)
				fe_ff <= 1'b1;
			else if (wr && paddr == `ASB_OFS_LSR && pwdata[`ASB_LS_FE])
				fe_ff <= 1'b0;
			if (rx_pe)
				pe_ff <= 1'b1;
			else if (wr && paddr == `ASB_OFS_LSR && pwdata[`ASB_LS_PE])
				pe_ff <= 1'b0;
			// Reading the interrupt status clears only the bits that the read returned.
			if (rd && paddr == `ASB_OFS_IST)
				ist_ff <= (ist_ff & ~prdata_ff[2:0]) | ev;
			else
				ist_ff <= ist_ff | ev;
		end
	end

	// Transmit frame, least significant first: start, data, optional mark or parity, stop bits.
	always @*
	begin
		nxt_frame = {12{1'b1}};
		if (data8)
		begin
			nxt_frame[8:0] = {tx_hold_ff, 1'b0};
			if (extra)
				nxt_frame[9] = mp ? mark_tx : asb_parity(tx_hold_ff, 1'b1, odd); // [R11] [R12] [R5]
		end
		else
		begin
			nxt_frame[7:0] = {tx_hold_ff[6:0], 1'b0};
			if (extra)
				nxt_frame[8] = mp ? mark_tx : asb_parity(tx_hold_ff, 1'b0, odd); // [R11] [R12] [R5]
		end
	end

	// Transmitter: one bit per oversample count, aborted when the transmitter is disabled.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state_ff <= TX_IDLE;
			tx_sr_ff <= {12{1'b1}};
			tx_bits_ff <= 4'h0;
			tx_cnt_ff <= 6'h00;
			txd_ff <= 1'b1;
		end
		else
		begin
			case (tx_state_ff)
				TX_IDLE:
				begin
					txd_ff <= 1'b1;
					tx_cnt_ff <= 6'h00;
					if (tx_load)
					begin
						tx_sr_ff <= nxt_frame;
						tx_bits_ff <= asb_frame_len(data8, extra, stop2);
						tx_state_ff <= TX_SHIFT;
					end
				end
				TX_SHIFT:
				begin
					txd_ff <= tx_sr_ff[0];
					if (!tx_en)
					begin
						tx_state_ff <= TX_IDLE;
					end
					else if (sample_tick)
					begin
						tx_cnt_ff <= tx_bit_end ? 6'h00 : tx_cnt_ff + 6'h01; // [R17]
						if (tx_bit_end)
						begin
							tx_sr_ff <= {1'b1, tx_sr_ff[11:1]};
							tx_bits_ff <= tx_bits_ff - 4'h1;
							if (tx_bits_ff == 4'h1)
								tx_state_ff <= TX_IDLE;
						end
					end
				end
				default:
				begin
					tx_state_ff <= TX_IDLE;
				end
			endcase
		end
	end

	// Align the received bits so that the first data bit sits at bit 0.
	always @*
	begin
		rx_full_sr = {rxd_s, rx_sr_ff[9:1]};
		rx_aligned = rx_full_sr >> (`ASB_RX_SR_W - rx_n);
	end

	// Receiver: start bit confirmed at mid-bit, then one sample per bit period through the first stop bit.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_state_ff <= RX_IDLE;
			rx_sr_ff <= 10'h000;
			rx_bits_ff <= 4'h0;
			rx_cnt_ff <= 6'h00;
		end
		else if (!rx_en)
		begin
			rx_state_ff <= RX_IDLE;
			rx_cnt_ff <= 6'h00;
		end
		else if (sample_tick)
		begin
			case (rx_state_ff)
				RX_IDLE:
				begin
					rx_cnt_ff <= 6'h00;
					if (!rxd_s)
						rx_state_ff <= RX_START;
				end
				RX_START:
				begin
					rx_cnt_ff <= rx_cnt_ff + 6'h01;
					if (rx_cnt_ff == osr_half - 6'h01)
					begin
						rx_cnt_ff <= 6'h00;
						rx_bits_ff <= rx_n;
						rx_state_ff <= rxd_s ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA:
				begin
					rx_cnt_ff <= rx_bit_end ? 6'h00 : rx_cnt_ff + 6'h01; // [R17]
					if (rx_bit_end)
					begin
						rx_sr_ff <= rx_full_sr;
						rx_bits_ff <= rx_bits_ff - 4'h1;
						if (rx_bits_ff == 4'h1)
							rx_state_ff <= RX_IDLE;
					end
				end
				default:
				begin
					rx_state_ff <= RX_IDLE;
				end
			endcase
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = pslverr_ff & access;
	assign txd = txd_ff;
	assign irq = |(ist_ff & imask_ff);
endmodule

// ### verif/asb_checker.sv
// Port checker for the serial channel: APB answers, read-back of the pin and line timing.
// Assumes it is bound to asb_top and sees only that module's ports.
module asb_checker (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave side
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Pins
	input wire cts_n_pin,
	input wire txd,
	input wire irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dclk @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	reg [2:0] cts_age_ff;
	reg cts_last_ff;
	// Counts how long the pin has held its level, so the synchroniser has settled.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cts_age_ff <= 3'h0;
			cts_last_ff <= 1'b0;
		end
		else
		begin
			cts_last_ff <= cts_n_pin;
			cts_age_ff <= (cts_n_pin != cts_last_ff) ? 3'h0 : ((cts_age_ff == 3'h7) ? 3'h7 : cts_age_ff + 3'h1);
		end
	end
	ready_high_a: assert property (pready) else $error("pready low");
	err_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
	err_unmapped_a: assert property (acc && paddr > 8'h18 |-> pslverr) else $error("no pslverr");
	err_mapped_a: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad pslverr");
	write_zero_a: assert property (acc && pwrite |-> prdata == 32'h0) else $error("prdata on write");
	unmap_zero_a: assert property (acc && paddr > 8'h18 |-> prdata == 32'h0) else $error("unmapped data");
	cts_read_a: assert property (acc && !pwrite && paddr == 8'h04 && cts_age_ff == 3'h7 |-> prdata[5] == cts_n_pin)
		else $error("pin read-back wrong");
	bit_hold_a: assert property ($changed(txd) |=> $stable(txd) [*8]) else $error("txd bit too short");
	reset_idle_a: assert property ($rose(presetn) |-> txd && !irq) else $error("not idle after reset");
	cover property ($fell(txd));
	cover property (acc && pslverr);
	cover property ($rose(irq));
endmodule

bind asb_top asb_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n_pin(cts_n_pin), .txd(txd), .irq(irq));

// ### verif/asb_station.sv
// Remote station on the shared line: times and samples frames from the channel and sends frames to it.
// Assumes the line idles high, pclk has a 4 ns period and data sent to it starts with a 1 bit.
module asb_station (
	// Clock
	input wire pclk,
	// Line
	input wire txd,
	output logic rxd,
	// Sampling length and results
	input wire [3:0] nbits,
	output logic [11:0] frame,
	output int low_w,
	output int starts,
	output int frames
);
	timeunit 1ns;
	timeprecision 1ps;
	time t0;
	initial rxd = 1'b1;
	// Times the start bit, then samples nbits bits at their centres when nbits is not zero.
	initial
	begin
		frame = 12'h000;
		starts = 0;
		frames = 0;
		forever
		begin
			@(negedge txd);
			t0 = $time;
			@(posedge txd);
			low_w = int'(($time - t0) / 4);
			starts++;
			if (nbits != 4'h0)
			begin
				repeat (low_w / 2) @(posedge pclk);
				for (int i = 0; i < nbits; i++)
				begin
					frame[i] = txd; // In 8-bit multidrop frames bit 8 is the address mark that listeners filter on.
					repeat (low_w) @(posedge pclk);
				end
				frames++;
			end
		end
	end
	// Sends a frame LSB first; the line goes back to idle high afterwards.
	task automatic send(input logic [10:0] bits, input int cyc);
		for (int k = 0; k < 11; k++)
		begin
			rxd <= bits[k];
			repeat (cyc) @(posedge pclk);
		end
		rxd <= 1'b1;
	endtask
endmodule

// ### verif/asb_top_tb_top.sv
// Testbench for the serial channel: APB tasks, rate, framing, receive gating and interrupt tests.
// Assumes asb_consts.vh is on the include path and the station model drives the receive pin.
`include "asb_consts.vh"
`define CHK(nm, ex, s) begin check_count++; if ((s) !== (ex)) begin failures++; $display("[ERR] %s exp %0h got %0h", nm, ex, s); end end
module asb_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, cts_n_pin, ext_clk_pin, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, q;
	logic [3:0] nb;
	wire [31:0] prdata;
	wire pready, pslverr, txd, irq, rxd;
	wire [11:0] frame;
	int low_w, starts, frames, failures, check_count, e, t;
	logic [7:0] cfg [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h20, 8'h07, 8'h27, 8'h0F};
	int expw [12] = '{160, 320, 640, 1280, 2560, 5120, 10240, 640, 480, 768, 768, 3072};
	logic [7:0] fca [5] = '{8'h34, 8'h34, 8'h36, 8'h36, 8'h34};
	logic [7:0] fcb [5] = '{8'hC0, 8'h40, 8'h00, 8'h10, 8'h00};
	logic [9:0] fex [5] = '{10'h3A5, 10'h2A5, 10'h2A5, 10'h3A5, 10'h3A5};
	asb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n_pin(cts_n_pin),
		.ext_clk_pin(ext_clk_pin), .rxd_pin(rxd), .txd(txd), .irq(irq));
	asb_station st (.pclk(pclk), .txd(txd), .rxd(rxd), .nbits(nb), .frame(frame), .low_w(low_w), .starts(starts),
		.frames(frames));
	// Clock at 250 MHz.
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// External clock at a 48-cycle period, slower than pclk/40.
	initial
	begin
		ext_clk_pin = 1'b0;
		forever
		begin
			repeat (24) @(posedge pclk);
			ext_clk_pin <= ~ext_clk_pin;
		end
	end
	task report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One APB transfer: setup, then access until pready; read data and error are taken at that edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			failures++;
			report_and_stop;
		end
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	// Waits for the station to see a start bit, or a whole frame.
	task automatic wait_evt(input bit fr);
		int old;
		int k;
		old = fr ? frames : starts;
		k = 0;
		while ((fr ? frames : starts) == old && k < 30000)
		begin
			@(posedge pclk);
			k++;
		end
		if (k >= 30000)
		begin
			failures++;
			report_and_stop;
		end
	endtask
	// Main sequence.
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cts_n_pin = 1'b0;
		nb = 4'h0;
		failures = 0;
		check_count = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`ASB_OFS_CTL_A);
		`CHK("ctl_a", 32'h34, q)
		rd(`ASB_OFS_CTL_B);
		`CHK("ctl_b", 32'h00, q)
		wr(8'h1C, 32'hFF);
		`CHK("slverr", 1'b1, err)
		rd(8'h1C);
		`CHK("unmapped", 32'h0, q)
		cts_n_pin <= 1'b1;
		wr(`ASB_OFS_CTL_B, 32'h00);
		rd(`ASB_OFS_CTL_B);
		`CHK("cts_high", 1'b1, q[5])
		cts_n_pin <= 1'b0;
		wr(`ASB_OFS_CTL_B, 32'h20);
		rd(`ASB_OFS_CTL_B);
		`CHK("cts_low", 1'b0, q[5])
		for (int i = 0; i < 12; i++)
		begin
			wr(`ASB_OFS_CTL_B, cfg[i]);
			wr(`ASB_OFS_TXD, 32'hA5);
			wait_evt(1'b0);
			e = expw[i];
			t = (cfg[i][2:0] == 3'h7) ? 48 : 1;
			`CHK("bit_width", 1'b1, (low_w >= e - t) && (low_w <= e + t))
			wr(`ASB_OFS_CTL_A, 32'h14);
			wr(`ASB_OFS_CTL_A, 32'h34);
		end
		nb <= 4'hA;
		for (int j = 0; j < 5; j++)
		begin
			wr(`ASB_OFS_CTL_A, fca[j]);
			wr(`ASB_OFS_CTL_B, fcb[j]);
			wr(`ASB_OFS_TXD, 32'hA5);
			wait_evt(1'b1);
			`CHK("frame", fex[j], frame[9:0])
		end
		wr(`ASB_OFS_CTL_A, 32'h3C);
		wr(`ASB_OFS_CTL_B, 32'h40);
		st.send({1'b1, 1'b0, 8'h5A, 1'b0}, 160);
		rd(`ASB_OFS_LSR);
		`CHK("unmarked_drop", 1'b0, q[0])
		st.send({1'b1, 1'b1, 8'h3C, 1'b0}, 160);
		rd(`ASB_OFS_LSR);
		`CHK("marked_full", 2'h3, {q[5], q[0]})
		rd(`ASB_OFS_RXD);
		`CHK("marked_data", 32'h3C, q)
		wr(`ASB_OFS_CTL_B, 32'h00);
		wr(`ASB_OFS_CTL_A, 32'h34);
		cts_n_pin <= 1'b1;
		st.send({2'b11, 8'h77, 1'b0}, 160);
		rd(`ASB_OFS_LSR);
		`CHK("cts_gate", 1'b0, q[0])
		cts_n_pin <= 1'b0;
		wr(`ASB_OFS_IMASK, 32'h1);
		rd(`ASB_OFS_IST);
		`CHK("irq_idle", 1'b0, irq)
		st.send({2'b11, 8'h77, 1'b0}, 160);
		`CHK("irq_set", 1'b1, irq)
		rd(`ASB_OFS_LSR);
		`CHK("cts_clear", 1'b1, q[0])
		wr(`ASB_OFS_IMASK, 32'h0);
		`CHK("irq_masked", 1'b0, irq)
		wr(`ASB_OFS_IMASK, 32'h1);
		`CHK("irq_unmasked", 1'b1, irq)
		rd(`ASB_OFS_IST);
		`CHK("ist_rx", 1'b1, q[0])
		`CHK("irq_cleared", 1'b0, irq)
		rd(`ASB_OFS_RXD);
		`CHK("rx_data", 32'h77, q)
		report_and_stop;
	end
endmodule
